/* rtl/cmc_defs.svh */
// Operation
// RL1: With wake enable set, bus traffic ends sleep; with it clear, traffic is ignored.
// RL2: A sleep request is served only when no reception runs and transmit buffers are empty.
// RL3: Sleep entry sets sleep acknowledge; sleep lasts until request cleared or wake-up.
// RL4: Init request aborts traffic, drops synchronisation, then sets init acknowledge; the code drops synchronisation one cycle after acknowledge.
// RL5: Init entry resets mode, flag, enable, abort and select registers; counters untouched.
// RL6: Configuration, timing and acceptance registers are writable only in init mode.
// RL7: After init exit, resync on 11 recessive bits, or 128 such runs in bus-off.
// RL8: Software writes other mode, flag and enable bits only after init fully exited.
// RL9: Clearing the sleep request is ignored until sleep has been entered.
// RL10: Clearing the init request is ignored until init mode has been entered.
// RL11: The transmit pin goes recessive at once when init is requested.
// RL12: The transmit pin goes recessive in stop, or in wait with stop-in-wait set.
// RL13: Software should enter sleep before requesting init mode.
// RL14: Module enable switches the controller; written in init, once in normal modes.
// RL15: Clock select picks oscillator clock at 0 and bus clock at 1.
// RL16: Loopback feeds transmitter to receiver, ignores receive pin, holds transmit pin recessive.
// RL17: Loopback takes own frame as received, ignores ack slot, raises transmit and receive flags.
// RL18: Listen-only receives matching frames, sends no ack or error, freezes counters, never transmits.
// RL19: Wake filter selects any falling edge, or a dominant pulse of minimum wake time.
// RL20: Software enables wake-on-bus and wake interrupt for recovery from stop or wait.
// RL21: Init mode is active only while init request and acknowledge are both set.
// RL22: While asleep with wake enabled, bus activity clears sleep acknowledge.
// RL23: With module enable clear the controller neither sends nor receives; transmit pin recessive.
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH
`define CMC_ADR_MODE 8'h00
`define CMC_ADR_CONF 8'h04
`define CMC_ADR_BT0 8'h08
`define CMC_ADR_BT1 8'h0C
`define CMC_ADR_RFLG 8'h10
`define CMC_ADR_RIER 8'h14
`define CMC_ADR_TFLG 8'h18
`define CMC_ADR_TIER 8'h1C
`define CMC_ADR_TARQ 8'h20
`define CMC_ADR_TAAK 8'h24
`define CMC_ADR_TBSEL 8'h28
`define CMC_ADR_IDAC 8'h2C
`define CMC_ADR_CODE 8'h40
`define CMC_ADR_MASK 8'h60
`define CMC_B_RXFRM 7
`define CMC_B_RXACT 6
`define CMC_B_STOP_IN_WAIT 5
`define CMC_B_SYNC 4
`define CMC_B_TIME 3
`define CMC_B_WAKE_EN 2
`define CMC_B_SLP_RQ 1
`define CMC_B_INIT_RQ 0
`define CMC_B_ENABLE 7
`define CMC_B_CLKSEL 6
`define CMC_B_LOOP 5
`define CMC_B_LISTEN 4
`define CMC_B_WFILT 2
`define CMC_B_SLP_AK 1
`define CMC_B_INIT_AK 0
`define CMC_B_RF_WAKE 7
`define CMC_B_RF_FULL 0
`define CMC_RST_TFLG 8'h07
`define CMC_RST_ZERO 8'h00
`define CMC_RECESSIVE_RUN 4'd11
`define CMC_BUSOFF_RUNS 8'd128
`define CMC_T_WUP_NS 5000
`define CMC_CLK_NS 4
`define CMC_WUP_CYC ((`CMC_T_WUP_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`endif

/* rtl/cmc_pkg.sv */
package cmc_pkg;
  typedef enum logic [1:0] {MD_RUN, MD_SLEEP, MD_INIT} cmc_mode_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cmc_wb_req_t;
  typedef struct packed {
    logic rx_busy;
    logic tx_all_empty;
    logic bus_off;
    logic bit_tick;
    logic tx_bit;
    logic tx_done;
    logic rx_done;
  } cmc_eng_sts_t;
  typedef struct packed {
    logic enable;
    logic abort;
    logic clk_sel;
    logic listen_only;
    logic ack_ignore;
    logic err_freeze;
    logic tx_allowed;
    logic timer_en;
    logic rx_bit;
  } cmc_eng_ctl_t;
endpackage : cmc_pkg

/* rtl/cmc_mode_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"
module cmc_mode_ctrl import cmc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cmc_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire cmc_eng_sts_t eng_i,
  output cmc_eng_ctl_t eng_o,
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  input wire logic cpu_stop_i,
  input wire logic cpu_wait_i,
  input wire logic special_mode_i,
  output logic wake_o
);
  cmc_mode_t mode_reg;
  cmc_mode_t mode_next;
  logic [7:0] mode_ctl_reg;
  logic [7:0] conf_reg;
  logic [7:0] bt0_reg;
  logic [7:0] bt1_reg;
  logic [7:0] rflg_reg;
  logic [7:0] rier_reg;
  logic [7:0] tflg_reg;
  logic [7:0] tier_reg;
  logic [7:0] tarq_reg;
  logic [7:0] taak_reg;
  logic [7:0] tbsel_reg;
  logic [7:0] idac_reg;
  logic [7:0] accept_reg [16];
  logic enable_written_reg;
  logic rx_prev_reg;
  logic [11:0] wup_cnt_reg;
  logic [3:0] rec_cnt_reg;
  logic [7:0] run_cnt_reg;
  logic ack_reg;
  logic [7:0] rdata_next;
  logic wr_fire;
  logic init_active;
  logic enter_init;
  logic idle;
  logic wake_evt;
  logic rx_eff;
  logic [7:0] wd;
  logic sync_reg;

  assign wr_fire = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !ack_reg && wb_req_i.sel[0];
  assign wd = wb_req_i.dat[7:0];
  assign init_active = mode_ctl_reg[`CMC_B_INIT_RQ] && (mode_reg == MD_INIT); // [RL21]
  assign enter_init = (mode_next == MD_INIT) && (mode_reg != MD_INIT);
  assign idle = !eng_i.rx_busy && eng_i.tx_all_empty; // [RL2]
  assign rx_eff = conf_reg[`CMC_B_LOOP] ? eng_i.tx_bit : rx_pin_i; // [RL16]

  // Wake detection: any falling edge, or a dominant pulse of the minimum wake time.
  always_comb begin
    wake_evt = 1'b0;
    if (mode_reg == MD_SLEEP && mode_ctl_reg[`CMC_B_WAKE_EN]) begin // [RL1]
      if (conf_reg[`CMC_B_WFILT]) begin
        wake_evt = (wup_cnt_reg == 12'(`CMC_WUP_CYC)); // [RL19]
      end else begin
        wake_evt = rx_prev_reg && !rx_pin_i; // [RL19]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_prev_reg <= 1'b1;
      wup_cnt_reg <= '0;
    end else begin
      rx_prev_reg <= rx_pin_i;
      if (rx_pin_i || mode_reg != MD_SLEEP) begin
        wup_cnt_reg <= '0;
      end else if (wup_cnt_reg != 12'(`CMC_WUP_CYC)) begin
        wup_cnt_reg <= wup_cnt_reg + 12'd1;
      end
    end
  end

  // Mode sequencing for sleep and init handshakes.
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MD_RUN: begin
        if (mode_ctl_reg[`CMC_B_INIT_RQ]) begin
          mode_next = MD_INIT; // [RL4]
        end else if (mode_ctl_reg[`CMC_B_SLP_RQ] && idle) begin
          mode_next = MD_SLEEP; // [RL2] [RL3]
        end
      end
      MD_SLEEP: begin
        if (mode_ctl_reg[`CMC_B_INIT_RQ]) begin
          mode_next = MD_INIT;
        end else if (!mode_ctl_reg[`CMC_B_SLP_RQ] || wake_evt) begin
          mode_next = MD_RUN; // [RL3] [RL22]
        end
      end
      MD_INIT: begin
        if (!mode_ctl_reg[`CMC_B_INIT_RQ]) begin
          mode_next = MD_RUN; // [RL7]
        end
      end
      default: mode_next = MD_INIT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= MD_INIT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Mode control register with guarded clears of the handshake requests.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ctl_reg <= 8'h01;
    end else begin
      if (enter_init) begin
        mode_ctl_reg <= mode_ctl_reg & 8'h07; // [RL5]
      end
      if (wr_fire && wb_req_i.adr == `CMC_ADR_MODE) begin
        mode_ctl_reg[`CMC_B_STOP_IN_WAIT] <= wd[`CMC_B_STOP_IN_WAIT];
        mode_ctl_reg[`CMC_B_TIME] <= wd[`CMC_B_TIME] && !init_active;
        mode_ctl_reg[`CMC_B_WAKE_EN] <= wd[`CMC_B_WAKE_EN];
        if (wd[`CMC_B_SLP_RQ] || mode_reg == MD_SLEEP) begin
          mode_ctl_reg[`CMC_B_SLP_RQ] <= wd[`CMC_B_SLP_RQ]; // [RL9]
        end
        if (wd[`CMC_B_INIT_RQ] || init_active) begin
          mode_ctl_reg[`CMC_B_INIT_RQ] <= wd[`CMC_B_INIT_RQ]; // [RL10]
        end
        if (wd[`CMC_B_RXFRM]) begin
          mode_ctl_reg[`CMC_B_RXFRM] <= 1'b0;
        end
      end
      if (wake_evt) begin
        mode_ctl_reg[`CMC_B_SLP_RQ] <= 1'b0; // [RL3]
      end
      if (eng_i.rx_done) begin
        mode_ctl_reg[`CMC_B_RXFRM] <= 1'b1;
      end
      mode_ctl_reg[`CMC_B_RXACT] <= eng_i.rx_busy && !init_active;
      if (init_active) begin
        mode_ctl_reg[`CMC_B_TIME] <= 1'b0;
      end
    end
  end

  // Configuration register: module enable is written once unless in a special mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conf_reg <= `CMC_RST_ZERO;
      enable_written_reg <= 1'b0;
    end else if (wr_fire && wb_req_i.adr == `CMC_ADR_CONF && init_active) begin // [RL6]
      conf_reg[6:2] <= wd[6:2]; // [RL15] [RL16] [RL18] [RL19]
      if (special_mode_i || !enable_written_reg) begin
        conf_reg[`CMC_B_ENABLE] <= wd[`CMC_B_ENABLE]; // [RL14]
        enable_written_reg <= !special_mode_i;
      end
    end
  end

  // Timing and acceptance registers, write protected outside init mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bt0_reg <= `CMC_RST_ZERO;
      bt1_reg <= `CMC_RST_ZERO;
      idac_reg <= `CMC_RST_ZERO;
      for (int i = 0; i < 16; i++) begin
        accept_reg[i] <= `CMC_RST_ZERO;
      end
    end else if (wr_fire && init_active) begin // [RL6]
      if (wb_req_i.adr == `CMC_ADR_BT0) begin
        bt0_reg <= wd;
      end
      if (wb_req_i.adr == `CMC_ADR_BT1) begin
        bt1_reg <= wd;
      end
      if (wb_req_i.adr == `CMC_ADR_IDAC) begin
        idac_reg <= wd;
      end
      if (wb_req_i.adr[7:6] == 2'b01 && wb_req_i.adr[1:0] == 2'b00) begin
        accept_reg[wb_req_i.adr[5:2]] <= wd;
      end
    end
  end

  // Flag, enable, abort and select registers, returned to defaults on init entry.
  always_ff @(posedge clk_i) begin
    if (rst_i || enter_init) begin // [RL5]
      rflg_reg <= `CMC_RST_ZERO;
      rier_reg <= `CMC_RST_ZERO;
      tflg_reg <= `CMC_RST_TFLG;
      tier_reg <= `CMC_RST_ZERO;
      tarq_reg <= `CMC_RST_ZERO;
      taak_reg <= `CMC_RST_ZERO;
      tbsel_reg <= `CMC_RST_ZERO;
    end else begin
      if (wr_fire) begin
        case (wb_req_i.adr)
          `CMC_ADR_RFLG: rflg_reg <= rflg_reg & ~wd;
          `CMC_ADR_RIER: rier_reg <= wd;
          `CMC_ADR_TFLG: tflg_reg <= tflg_reg & ~wd;
          `CMC_ADR_TIER: tier_reg <= wd;
          `CMC_ADR_TARQ: tarq_reg <= wd;
          `CMC_ADR_TAAK: taak_reg <= wd;
          `CMC_ADR_TBSEL: tbsel_reg <= wd;
          default: ;
        endcase
      end
      if (eng_i.rx_done || (conf_reg[`CMC_B_LOOP] && eng_i.tx_done)) begin
        rflg_reg[`CMC_B_RF_FULL] <= 1'b1; // [RL17]
      end
      if (eng_i.tx_done) begin
        tflg_reg[0] <= 1'b1; // [RL17]
      end
      if (wake_evt) begin
        rflg_reg[`CMC_B_RF_WAKE] <= 1'b1;
      end
    end
  end

  // Resynchronisation after init exit.
  always_ff @(posedge clk_i) begin
    if (rst_i || mode_reg != MD_RUN || !conf_reg[`CMC_B_ENABLE]) begin
      rec_cnt_reg <= '0;
      run_cnt_reg <= '0;
    end else if (eng_i.bit_tick && !sync_reg) begin
      if (!rx_eff) begin
        rec_cnt_reg <= '0;
      end else if (rec_cnt_reg == `CMC_RECESSIVE_RUN - 4'd1) begin
        rec_cnt_reg <= '0;
        run_cnt_reg <= run_cnt_reg + 8'd1; // [RL7]
      end else begin
        rec_cnt_reg <= rec_cnt_reg + 4'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || mode_reg != MD_RUN || !conf_reg[`CMC_B_ENABLE]) begin
      sync_reg <= 1'b0; // [RL4]
    end else if (eng_i.bit_tick && rx_eff && rec_cnt_reg == `CMC_RECESSIVE_RUN - 4'd1) begin
      if (!eng_i.bus_off || run_cnt_reg == `CMC_BUSOFF_RUNS - 8'd1) begin
        sync_reg <= 1'b1; // [RL7]
      end
    end
  end

  // Read mux.
  always_comb begin
    rdata_next = 8'h00;
    case (wb_req_i.adr)
      `CMC_ADR_MODE: rdata_next = {mode_ctl_reg[7:5], sync_reg, mode_ctl_reg[3:0]};
      `CMC_ADR_CONF: rdata_next = {conf_reg[7:2], mode_reg == MD_SLEEP, mode_reg == MD_INIT};
      `CMC_ADR_BT0: rdata_next = bt0_reg;
      `CMC_ADR_BT1: rdata_next = bt1_reg;
      `CMC_ADR_RFLG: rdata_next = rflg_reg;
      `CMC_ADR_RIER: rdata_next = rier_reg;
      `CMC_ADR_TFLG: rdata_next = tflg_reg;
      `CMC_ADR_TIER: rdata_next = tier_reg;
      `CMC_ADR_TARQ: rdata_next = tarq_reg;
      `CMC_ADR_TAAK: rdata_next = taak_reg;
      `CMC_ADR_TBSEL: rdata_next = tbsel_reg;
      `CMC_ADR_IDAC: rdata_next = idac_reg;
      default: begin
        if (wb_req_i.adr[7:6] == 2'b01 && wb_req_i.adr[1:0] == 2'b00) begin
          rdata_next = accept_reg[wb_req_i.adr[5:2]];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req_i.cyc && wb_req_i.stb && !ack_reg;
      wb_dat_o <= {24'h00_0000, rdata_next};
    end
  end
  assign wb_ack_o = ack_reg;

  // Protocol-engine controls and pins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng_o <= '0;
      tx_pin_o <= 1'b1;
      wake_o <= 1'b0;
    end else begin
      eng_o.enable <= conf_reg[`CMC_B_ENABLE] && mode_next == MD_RUN; // [RL23]
      eng_o.abort <= mode_ctl_reg[`CMC_B_INIT_RQ]; // [RL4]
      eng_o.clk_sel <= conf_reg[`CMC_B_CLKSEL]; // [RL15]
      eng_o.listen_only <= conf_reg[`CMC_B_LISTEN];
      eng_o.ack_ignore <= conf_reg[`CMC_B_LOOP]; // [RL17]
      eng_o.err_freeze <= conf_reg[`CMC_B_LISTEN]; // [RL18]
      eng_o.tx_allowed <= !conf_reg[`CMC_B_LISTEN] && sync_reg; // [RL18]
      eng_o.timer_en <= mode_ctl_reg[`CMC_B_TIME];
      eng_o.rx_bit <= conf_reg[`CMC_B_ENABLE] ? rx_eff : 1'b1; // [RL16] [RL23]
      wake_o <= wake_evt && rier_reg[`CMC_B_RF_WAKE];
      if (mode_ctl_reg[`CMC_B_INIT_RQ] || (wr_fire && wb_req_i.adr == `CMC_ADR_MODE && wd[0]) // [RL11]
          || cpu_stop_i || (cpu_wait_i && mode_ctl_reg[`CMC_B_STOP_IN_WAIT]) // [RL12]
          || conf_reg[`CMC_B_LOOP] || conf_reg[`CMC_B_LISTEN] || !conf_reg[`CMC_B_ENABLE] // [RL16] [RL23]
          || mode_reg != MD_RUN || !sync_reg) begin
        tx_pin_o <= 1'b1;
      end else begin
        tx_pin_o <= eng_i.tx_bit;
      end
    end
  end

  sequence init_req_s;
    mode_ctl_reg[`CMC_B_INIT_RQ] && mode_reg != MD_INIT;
  endsequence
  sequence sleep_ok_s;
    mode_reg == MD_RUN && mode_ctl_reg[`CMC_B_SLP_RQ] && !mode_ctl_reg[`CMC_B_INIT_RQ] && idle;
  endsequence

  init_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) init_req_s |=> mode_reg == MD_INIT) // [RL4]
    else $error("init acknowledge not given");
  sleep_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) sleep_ok_s |=> mode_reg == MD_SLEEP) // [RL2]
    else $error("sleep not entered when idle");
  sleep_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reg == MD_RUN && !idle |=> mode_reg != MD_SLEEP) // [RL2]
    else $error("sleep entered while busy");
  init_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_ctl_reg[`CMC_B_INIT_RQ] && mode_reg != MD_INIT |=> mode_ctl_reg[`CMC_B_INIT_RQ]) // [RL10]
    else $error("init request cleared early");
  sleep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_ctl_reg[`CMC_B_SLP_RQ] && mode_reg == MD_RUN |=> mode_ctl_reg[`CMC_B_SLP_RQ]) // [RL9]
    else $error("sleep request cleared early");
  tx_init_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_ctl_reg[`CMC_B_INIT_RQ] |=> tx_pin_o) // [RL11]
    else $error("transmit pin not recessive in init");
  tx_loop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conf_reg[`CMC_B_LOOP] || cpu_stop_i || !conf_reg[`CMC_B_ENABLE] |=> tx_pin_o) // [RL16]
    else $error("transmit pin driven when it must be recessive");
  wake_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_evt |=> !mode_ctl_reg[`CMC_B_SLP_RQ] && mode_reg == MD_RUN) // [RL22]
    else $error("wake did not leave sleep");
  wake_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reg == MD_SLEEP && !mode_ctl_reg[`CMC_B_WAKE_EN] && mode_ctl_reg[`CMC_B_SLP_RQ]
    && !mode_ctl_reg[`CMC_B_INIT_RQ] |=> mode_reg == MD_SLEEP) // [RL1]
    else $error("woke with wake-up disabled");
  conf_prot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !init_active |=> $stable(conf_reg)) // [RL6]
    else $error("configuration changed outside init");
  tx_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL12]
    cpu_wait_i && mode_ctl_reg[`CMC_B_STOP_IN_WAIT] |=> tx_pin_o)
    else $error("transmit pin driven in wait with stop-in-wait set");
  tx_listen_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL18]
    conf_reg[`CMC_B_LISTEN] |=> !eng_o.tx_allowed && tx_pin_o)
    else $error("transmission possible in listen-only mode");
  enable_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL23]
    !conf_reg[`CMC_B_ENABLE] |=> !eng_o.enable && eng_o.rx_bit)
    else $error("engine active while module disabled");
  init_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
    enter_init |=> tflg_reg == `CMC_RST_TFLG && tier_reg == `CMC_RST_ZERO)
    else $error("flag registers not reset on init entry");
  abort_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
    mode_ctl_reg[`CMC_B_INIT_RQ] |=> eng_o.abort)
    else $error("traffic not aborted on init request");
  clk_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL15]
    conf_reg[`CMC_B_CLKSEL] |=> eng_o.clk_sel)
    else $error("bus clock not selected");
  loop_rx_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL16]
    conf_reg[`CMC_B_LOOP] && conf_reg[`CMC_B_ENABLE] |=> eng_o.rx_bit == $past(eng_i.tx_bit))
    else $error("loopback does not feed the receiver");
endmodule : cmc_mode_ctrl
`default_nettype wire

/* bench/cmc_bus_node.sv */
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_node (
  input wire logic clk_i,
  output logic rx_o
);
  // The bus idles recessive through its pull-up between frames.
  initial rx_o = 1'b1;

  task automatic level(input logic v);
    @(posedge clk_i);
    rx_o <= v;
  endtask : level

  // A dominant pulse of n clock cycles, then release to recessive.
  task automatic pulse(input int n);
    level(1'b0);
    repeat (n) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask : pulse
endmodule : cmc_bus_node
`default_nettype wire

/* bench/can_mode_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"
module can_mode_control_tb_top import cmc_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  cmc_wb_req_t req = '0;
  logic [31:0] dat;
  logic ack;
  cmc_eng_ctl_t ctl;
  cmc_eng_sts_t eng;
  logic rx_busy = 1'b0;
  logic tx_bit = 1'b1;
  logic tick = 1'b0;
  logic tx_done = 1'b0;
  logic rx_done = 1'b0;
  logic stop = 1'b0;
  logic cwait = 1'b0;
  logic spec = 1'b0;
  logic woke = 1'b0;
  logic tx;
  logic rx;
  logic wake;
  logic [7:0] q;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int div = 0;

  assign eng = '{rx_busy, 1'b1, 1'b0, tick, tx_bit, tx_done, rx_done};

  cmc_mode_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
    .eng_i(eng), .eng_o(ctl), .rx_pin_i(rx), .tx_pin_o(tx), .cpu_stop_i(stop), .cpu_wait_i(cwait),
    .special_mode_i(spec), .wake_o(wake));
  cmc_bus_node bus (.clk_i(clk_i), .rx_o(rx));

  initial forever #2 clk_i = ~clk_i;

  // Bit ticks every fourth cycle, a sticky wake record and the hang limit.
  always @(posedge clk_i) begin
    div <= (div == 3) ? 0 : div + 1;
    tick <= (div == 3);
    cycles <= cycles + 1;
    if (wake === 1'b1) woke <= 1'b1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h00_0000, d}};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = dat[7:0];
    req <= '0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  task automatic pin(input logic e);
    wt(2);
    @(negedge clk_i);
    chk({7'h00, tx}, {7'h00, e});
    @(posedge clk_i);
  endtask : pin

  // Enter init, load the configuration, leave init and wait for resync.
  task automatic cfg(input logic [7:0] c);
    wr(`CMC_ADR_MODE, 8'h02);
    wt(5);
    wr(`CMC_ADR_MODE, 8'h03);
    wr(`CMC_ADR_CONF, c);
    wr(`CMC_ADR_MODE, 8'h00);
    wr(`CMC_ADR_MODE, 8'h00);
    wt(60);
  endtask : cfg

  initial begin
    wt(16);
    rst_i <= 1'b0;
    rd(`CMC_ADR_MODE, 8'hFF, 8'h01);
    rd(`CMC_ADR_CONF, 8'hFF, 8'h01);
    pin(1'b1);
    wr(`CMC_ADR_CONF, 8'hC0);
    rd(`CMC_ADR_CONF, 8'hFF, 8'hC1);
    chk({7'h00, ctl.clk_sel}, 8'h01);
    wr(`CMC_ADR_BT0, 8'h55);
    wr(`CMC_ADR_MODE, 8'h00);
    rd(`CMC_ADR_CONF, 8'h01, 8'h00);
    wr(`CMC_ADR_BT0, 8'hAA);
    rd(`CMC_ADR_BT0, 8'hFF, 8'h55);
    wt(60);
    rd(`CMC_ADR_MODE, 8'h10, 8'h10);
    wr(`CMC_ADR_TIER, 8'h55);
    tx_bit <= 1'b0;
    pin(1'b0);
    stop <= 1'b1;
    pin(1'b1);
    stop <= 1'b0;
    wr(`CMC_ADR_MODE, 8'h20);
    cwait <= 1'b1;
    pin(1'b1);
    cwait <= 1'b0;
    wr(`CMC_ADR_MODE, 8'h01);
    pin(1'b1);
    rd(`CMC_ADR_CONF, 8'h01, 8'h01);
    rd(`CMC_ADR_TIER, 8'hFF, 8'h00);
    rd(`CMC_ADR_TFLG, 8'hFF, 8'h07);
    wr(`CMC_ADR_CONF, 8'h00);
    rd(`CMC_ADR_CONF, 8'h80, 8'h80);
    spec <= 1'b1;
    wr(`CMC_ADR_CONF, 8'h00);
    rd(`CMC_ADR_CONF, 8'h80, 8'h00);
    wr(`CMC_ADR_MODE, 8'h00);
    wt(60);
    pin(1'b1);
    cfg(8'hA0);
    pin(1'b1);
    chk({5'h00, ctl.enable, ctl.rx_bit, ctl.ack_ignore}, 8'h05);
    bus.level(1'b0);
    tx_bit <= 1'b1;
    pin(1'b1);
    chk({6'h00, ctl.rx_bit, ctl.ack_ignore}, 8'h03);
    bus.level(1'b1);
    tx_bit <= 1'b0;
    wr(`CMC_ADR_TFLG, 8'h01);
    rd(`CMC_ADR_TFLG, 8'h01, 8'h00);
    tx_done <= 1'b1;
    wt(1);
    tx_done <= 1'b0;
    rd(`CMC_ADR_TFLG, 8'h01, 8'h01);
    rd(`CMC_ADR_RFLG, 8'h01, 8'h01);
    cfg(8'h90);
    pin(1'b1);
    chk({5'h00, ctl.listen_only, ctl.err_freeze, ctl.tx_allowed}, 8'h06);
    rx_done <= 1'b1;
    wt(1);
    rx_done <= 1'b0;
    rd(`CMC_ADR_MODE, 8'h80, 8'h80);
    rd(`CMC_ADR_RFLG, 8'h01, 8'h01);
    cfg(8'h80);
    wr(`CMC_ADR_RIER, 8'h80);
    rx_busy <= 1'b1;
    wr(`CMC_ADR_MODE, 8'h06);
    wt(5);
    rd(`CMC_ADR_CONF, 8'h02, 8'h00);
    wr(`CMC_ADR_MODE, 8'h04);
    rd(`CMC_ADR_MODE, 8'h07, 8'h06);
    rx_busy <= 1'b0;
    wt(5);
    rd(`CMC_ADR_CONF, 8'h02, 8'h02);
    bus.pulse(3);
    wt(5);
    rd(`CMC_ADR_MODE, 8'h02, 8'h00);
    rd(`CMC_ADR_CONF, 8'h02, 8'h00);
    chk({7'h00, woke}, 8'h01);
    rd(`CMC_ADR_RFLG, 8'h80, 8'h80);
    wr(`CMC_ADR_MODE, 8'h02);
    wt(5);
    rd(`CMC_ADR_CONF, 8'h02, 8'h02);
    bus.pulse(3);
    wt(5);
    rd(`CMC_ADR_CONF, 8'h02, 8'h02);
    wr(`CMC_ADR_MODE, 8'h00);
    rd(`CMC_ADR_CONF, 8'h02, 8'h00);
    cfg(8'h84);
    wr(`CMC_ADR_MODE, 8'h06);
    wt(5);
    bus.pulse(100);
    wt(5);
    rd(`CMC_ADR_CONF, 8'h02, 8'h02);
    bus.pulse(1300);
    wt(5);
    rd(`CMC_ADR_CONF, 8'h02, 8'h00);
    summarize();
  end
endmodule : can_mode_control_tb_top
`default_nettype wire
